// ==== rtl/sdram_read_burst_control.sv ====
// read burst control: latency, burst length, strobe, auto precharge, apb registers
`timescale 1ns/1ps
`include "rd_burst_defines.svh"
module sdram_read_burst_control #(
    parameter int DQ_W  = 8,
    parameter int DEPTH = 64
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // register bus
    input  wire rd_burst_pkg::apb_req_s   apb_req,
    output rd_burst_pkg::apb_rsp_s        apb_rsp,
    // command bus from the controller
    input  wire rd_burst_pkg::cmd_s       cmd,
    // array read port, two beats per clock
    output logic [13:0]                   fetch_addr,
    input  wire logic [2*DQ_W-1:0]        fetch_data,
    // data and strobe pins, rising beat in the high half
    output logic [2*DQ_W-1:0]             dq_out,
    output logic                          dq_oe_n,
    output logic [1:0]                    dqs_out,
    output logic                          dqs_oe_n,
    // write data window and precharge events
    output logic                          wr_data_expect,
    output logic                          precharge_start,
    output logic [3:0]                    precharge_bank
);
    // register file
    logic [31:0] mode_r;
    logic [31:0] lat_r;
    logic [15:0] bank_open_r;
    logic [2:0]  err_r;
    logic [31:0] prdata_r;

    wire         setup_ph  = apb_req.psel & ~apb_req.penable;
    wire         access_ph = apb_req.psel & apb_req.penable;
    wire         hit_mode  = apb_req.paddr == `REG_MODE;
    wire         hit_lat   = apb_req.paddr == `REG_LAT;
    wire         hit_bank  = apb_req.paddr == `REG_BANK;
    wire         hit_err   = apb_req.paddr == `REG_ERR;
    wire         mapped    = hit_mode | hit_lat | hit_bank | hit_err;
    wire         wr_acc    = access_ph & apb_req.pwrite & mapped;
    wire [31:0]  rd_mux    = hit_mode ? mode_r :
                             hit_lat  ? lat_r :
                             hit_bank ? {16'h0000, bank_open_r} :
                             hit_err  ? {29'h0000_000, err_r} : 32'h0000_0000;

    assign apb_rsp.prdata  = prdata_r;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = access_ph & ~mapped;

    // configuration fields
    wire [1:0]   bl_mode = mode_r[`BL_LSB +: 2];
    wire         rpre2   = mode_r[`RPRE2_BIT];
    wire         wpre2   = mode_r[`WPRE2_BIT];
    wire [4:0]   cl      = lat_r[`CL_LSB +: 5];
    wire [4:0]   cas_write_latency     = lat_r[`CWL_LSB +: 5];
    wire [4:0]   al      = lat_r[`AL_LSB +: 5];
    wire [5:0]   rl_w    = {1'b0, al} + {1'b0, cl};
    wire [5:0]   wl_w    = {1'b0, al} + {1'b0, cas_write_latency};

    // incoming command decode
    wire         is_rd   = cmd.code == rd_burst_pkg::CMD_RD;
    wire         is_wr   = cmd.code == rd_burst_pkg::CMD_WR;
    wire         is_act  = cmd.code == rd_burst_pkg::CMD_ACT;
    wire         is_pre  = cmd.code == rd_burst_pkg::CMD_PRE;
    // reserved mode 11 behaves as fixed eight
    wire         chop_w  = (bl_mode == `BL_FIXED4) |
                           ((bl_mode == `BL_OTF) & ~cmd.chop_select_addr_bit);

    rd_burst_pkg::token_s tok_in;
    rd_burst_pkg::token_s slot [DEPTH];

    assign tok_in.valid    = is_rd | is_wr;
    assign tok_in.is_write = is_wr;
    assign tok_in.chop     = chop_w;
    assign tok_in.ap       = cmd.auto_precharge_addr_bit;
    assign tok_in.bank     = cmd.bank;
    assign tok_in.col      = cmd.col;

    cmd_delay_line #(.DEPTH(DEPTH)) u_delay (
        .clk    (clk),
        .rst    (rst),
        .tok_in (tok_in),
        .slot   (slot)
    );

    // taps: slot k drives pins k+2 cycles after the command
    function automatic logic [5:0] tap(input logic [5:0] lat, input logic [5:0] back);
        tap = (lat > back + 6'd2) ? lat - back - 6'd2 : 6'd0;
    endfunction

    rd_burst_pkg::token_s rd_tok;
    rd_burst_pkg::token_s pre1_tok;
    rd_burst_pkg::token_s pre2_tok;
    rd_burst_pkg::token_s wr_tok;
    assign rd_tok   = slot[tap(rl_w, 6'd0)];
    assign pre1_tok = slot[tap(rl_w, 6'd1)];
    assign pre2_tok = slot[tap(rl_w, 6'd2)];
    assign wr_tok   = slot[tap(wl_w, 6'd0)];

    wire rd_start = rd_tok.valid & ~rd_tok.is_write;
    wire pre_soon = (pre1_tok.valid & ~pre1_tok.is_write) |
                    (rpre2 & pre2_tok.valid & ~pre2_tok.is_write);

    // burst engine
    rd_burst_pkg::token_s cur_r;
    logic [2:0]  clk_left_r;
    logic [1:0]  pair_r;
    logic [2:0]  clk_left_nxt;
    logic [1:0]  pair_nxt;
    wire         last_clk  = clk_left_r == 3'h1;
    // a new burst may take over the very edge the old one ends
    wire         burst_end = last_clk & ~rd_start;
    wire         ap_fire   = burst_end & cur_r.ap;

    always_comb begin
        clk_left_nxt = (clk_left_r != 3'h0) ? clk_left_r - 3'h1 : 3'h0;
        pair_nxt     = pair_r + 2'h1;
        if (rd_start) begin
            clk_left_nxt = rd_tok.chop ? `CLK_BC4 : `CLK_BL8;
            // pair 0 is fetched in the start cycle, so the next fetch is pair 1
            pair_nxt     = 2'h1;
        end
    end

    assign fetch_addr = rd_start ? {rd_tok.bank, rd_tok.col} :
                        {cur_r.bank, cur_r.col + {7'h00, pair_r, 1'b0}};

    wire data_nxt = clk_left_nxt != 3'h0;

    always_ff @(posedge clk) begin
        if (rst) begin
            cur_r      <= '0;
            clk_left_r <= 3'h0;
            pair_r     <= 2'h0;
            dq_out     <= '0;
            dq_oe_n    <= 1'b1;
            dqs_out    <= 2'b00;
            dqs_oe_n   <= 1'b1;
        end else begin
            if (rd_start)
                cur_r <= rd_tok;
            clk_left_r <= clk_left_nxt;
            pair_r     <= pair_nxt;
            dq_out     <= data_nxt ? fetch_data : '0;
            dq_oe_n    <= ~data_nxt;
            // two strobe edges per data clock, held low through the preamble
            dqs_out    <= data_nxt ? 2'b10 : 2'b00;
            dqs_oe_n   <= ~(data_nxt | pre_soon);
        end
    end

    // write window and precharge pulses
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_data_expect  <= 1'b0;
            precharge_start <= 1'b0;
            precharge_bank  <= 4'h0;
        end else begin
            wr_data_expect  <= wr_tok.valid & wr_tok.is_write;
            precharge_start <= ap_fire;
            precharge_bank  <= ap_fire ? cur_r.bank : precharge_bank;
        end
    end

    // spacing monitors; saturating so long idle never wraps into a false hit
    logic [7:0]  since_rd_r;
    logic        last_chop_r;
    logic [7:0]  since_ap_r;
    wire  [9:0]  rbl_w   = last_chop_r ? `RBL_BC4 : `RBL_BL8;
    wire  [9:0]  r2w_min = {5'h00, cl} - {5'h00, cas_write_latency} + {1'b0, rbl_w[9:1]}
                           + 10'h001 + (wpre2 ? 10'h002 : 10'h001);
    wire  [9:0]  rtp_ck  = (`RTP_CK > `RTP_MIN_CK) ? 10'(`RTP_CK) : 10'(`RTP_MIN_CK);
    wire         cl_gt   = {5'h00, cl} + 10'h004 >= {5'h00, cas_write_latency};
    wire         err_rd5 = is_rd & rpre2 & (since_rd_r == `RD_SPACING_BAD);
    wire         err_r2w = is_wr & cl_gt & ({2'b00, since_rd_r} < r2w_min);
    wire         err_rtp = is_pre & ({2'b00, since_ap_r} < {5'h00, al} + rtp_ck);

    always_ff @(posedge clk) begin
        if (rst) begin
            since_rd_r  <= 8'hFF;
            last_chop_r <= 1'b0;
            since_ap_r  <= 8'hFF;
        end else begin
            since_rd_r  <= is_rd ? 8'h01 : (since_rd_r == 8'hFF ? 8'hFF : since_rd_r + 8'h01);
            since_ap_r  <= is_rd ? 8'h01 : (since_ap_r == 8'hFF ? 8'hFF : since_ap_r + 8'h01);
            if (is_rd)
                last_chop_r <= chop_w;
        end
    end

    // bank state
    logic [15:0] bank_open_nxt;
    always_comb begin
        bank_open_nxt = bank_open_r;
        if (ap_fire)
            bank_open_nxt[cur_r.bank] = 1'b0;
        if (is_pre)
            bank_open_nxt[cmd.bank] = 1'b0;
        if (is_act)
            bank_open_nxt[cmd.bank] = 1'b1;
    end

    // register writes; error flags are write-one-to-clear and a new hit wins
    wire [2:0] err_set = {err_rtp, err_r2w, err_rd5};
    wire [2:0] err_clr = (wr_acc & hit_err) ? apb_req.pwdata[2:0] : 3'b000;

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_r      <= `MODE_RST;
            lat_r       <= `LAT_RST;
            bank_open_r <= 16'h0000;
            err_r       <= 3'b000;
            prdata_r    <= 32'h0000_0000;
        end else begin
            if (wr_acc & hit_mode)
                mode_r <= {28'h0000_000, apb_req.pwdata[3:0]};
            if (wr_acc & hit_lat)
                lat_r <= {11'h000, apb_req.pwdata[20:16], 3'h0,
                          apb_req.pwdata[12:8], 3'h0, apb_req.pwdata[4:0]};
            bank_open_r <= bank_open_nxt;
            err_r       <= (err_r & ~err_clr) | err_set;
            if (setup_ph)
                prdata_r <= rd_mux;
        end
    end
endmodule

// ==== rtl/rd_burst_defines.svh ====
// register map, field positions, reset values and timing counts of the read burst block
`ifndef RD_BURST_DEFINES_SVH
`define RD_BURST_DEFINES_SVH

`define REG_MODE        8'h00
`define REG_LAT         8'h04
`define REG_BANK        8'h08
`define REG_ERR         8'h0C

`define BL_LSB          0
`define RPRE2_BIT       2
`define WPRE2_BIT       3
`define CL_LSB          0
`define CWL_LSB         8
`define AL_LSB          16
`define ERR_RD5_BIT     0
`define ERR_R2W_BIT     1
`define ERR_RTP_BIT     2

`define MODE_RST        32'h0000_0000
`define LAT_RST         32'h0000_090B

`define BL_FIXED8       2'b00
`define BL_OTF          2'b01
`define BL_FIXED4       2'b10

`define CLK_BL8         3'h4
`define CLK_BC4         3'h2
`define RBL_BL8         10'h008
`define RBL_BC4         10'h004
`define RD_SPACING_BAD  8'h05

`define TCK_PS          10000
`define RTP_MIN_PS      7500
`define RTP_MIN_CK      4
`define RTP_CK          ((`RTP_MIN_PS + `TCK_PS - 1) / `TCK_PS)

`endif

// ==== rtl/rd_burst_pkg.sv ====
// types shared by the read burst block
package rd_burst_pkg;
    typedef enum logic [2:0] {CMD_DES, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE} cmd_e;

    typedef struct packed {
        cmd_e       code;
        logic [3:0] bank;
        logic       auto_precharge_addr_bit;
        logic       chop_select_addr_bit;
        logic [9:0] col;
    } cmd_s;

    typedef struct packed {
        logic       valid;
        logic       is_write;
        logic       chop;
        logic       ap;
        logic [3:0] bank;
        logic [9:0] col;
    } token_s;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_s;
endpackage

// ==== rtl/cmd_delay_line.sv ====
// command token delay line, slot i holds the token of i+1 cycles ago
`timescale 1ns/1ps
module cmd_delay_line #(
    parameter int DEPTH = 64
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // token in and taps out
    input  wire rd_burst_pkg::token_s tok_in,
    output rd_burst_pkg::token_s      slot [DEPTH]
);
    rd_burst_pkg::token_s slot_r [DEPTH];

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_slot
            always_ff @(posedge clk) begin
                if (rst)
                    slot_r[i] <= '0;
                else if (i == 0)
                    slot_r[i] <= tok_in;
                else
                    slot_r[i] <= slot_r[(i == 0) ? 0 : i - 1];
            end
            assign slot[i] = slot_r[i];
        end
    endgenerate
endmodule

// ==== dv/rd_burst_monitor.sv ====
// concurrent checks on the ports of the read burst block
`timescale 1ns/1ps
module rd_burst_monitor #(
    parameter int DQ_W = 8
) (
    // clock and reset
    input wire logic                   clk,
    input wire logic                   rst,
    // register bus
    input wire rd_burst_pkg::apb_req_s apb_req,
    input wire rd_burst_pkg::apb_rsp_s apb_rsp,
    // command bus and array port
    input wire rd_burst_pkg::cmd_s     cmd,
    input wire logic [13:0]            fetch_addr,
    input wire logic [2*DQ_W-1:0]      fetch_data,
    // pins and events
    input wire logic [2*DQ_W-1:0]      dq_out,
    input wire logic                   dq_oe_n,
    input wire logic [1:0]             dqs_out,
    input wire logic                   dqs_oe_n,
    input wire logic                   wr_data_expect,
    input wire logic                   precharge_start,
    input wire logic [3:0]             precharge_bank
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire access_cycle = apb_req.psel && apb_req.penable;
    property p_strobe_data; !dq_oe_n |-> !dqs_oe_n && dqs_out == 2'b10; endproperty
    a_strobe_data: assert property (p_strobe_data) else $error("strobe idle in data");
    property p_pre_low; !dqs_oe_n && dq_oe_n |-> dqs_out == 2'b00; endproperty
    a_pre_low: assert property (p_pre_low) else $error("preamble strobe moved");
    property p_pre_lead; $fell(dqs_oe_n) |-> dq_oe_n ##[1:2] !dq_oe_n; endproperty
    a_pre_lead: assert property (p_pre_lead) else $error("preamble without data");
    property p_min_burst; $fell(dq_oe_n) |-> !dq_oe_n [*2]; endproperty
    a_min_burst: assert property (p_min_burst) else $error("burst too short");
    property p_ap_after; precharge_start |-> dq_oe_n && $past(dq_oe_n) == 1'b0; endproperty
    a_ap_after: assert property (p_ap_after) else $error("precharge not after burst");
    property p_ap_pulse; precharge_start |=> !precharge_start; endproperty
    a_ap_pulse: assert property (p_ap_pulse) else $error("precharge pulse too long");
    property p_ap_bank; $changed(precharge_bank) |-> precharge_start; endproperty
    a_ap_bank: assert property (p_ap_bank) else $error("bank moved without precharge");
    property p_wr_pulse; wr_data_expect |=> !wr_data_expect; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write window too long");
    property p_ready; access_cycle |-> apb_rsp.pready; endproperty
    a_ready: assert property (p_ready) else $error("apb not ready");
    property p_slverr; apb_rsp.pslverr |-> access_cycle; endproperty
    a_slverr: assert property (p_slverr) else $error("error outside access");
    c_ap: cover property (precharge_start);
    c_wr: cover property (wr_data_expect);
    c_err: cover property (apb_rsp.pslverr);
endmodule

bind sdram_read_burst_control rd_burst_monitor #(.DQ_W(DQ_W)) u_rd_burst_monitor (.*);

// ==== dv/array_model.sv ====
// behavioural array answering each fetch in the same cycle
`timescale 1ns/1ps
module array_model #(
    parameter int DQ_W = 8
) (
    // array read port
    input  wire logic [13:0]       fetch_addr,
    output logic      [2*DQ_W-1:0] fetch_data
);
    // address-shaped pattern so a wrong column shows at once
    assign fetch_data = {fetch_addr[DQ_W-1:0], ~fetch_addr[DQ_W-1:0]};
endmodule

// ==== dv/sdram_read_burst_control_tb.sv ====
// self-checking bench of the read burst block
`timescale 1ns/1ps
`include "rd_burst_defines.svh"
module sdram_read_burst_control_tb;
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    rd_burst_pkg::apb_req_s apb_req = '0;
    rd_burst_pkg::apb_rsp_s apb_rsp;
    rd_burst_pkg::cmd_s     cmd = '0;
    logic [13:0]            fetch_addr;
    logic [15:0]            fetch_data;
    logic [15:0]            dq_out;
    logic [1:0]             dqs_out;
    logic                   dq_oe_n;
    logic                   dqs_oe_n;
    logic                   wr_data_expect;
    logic                   precharge_start;
    logic [3:0]             precharge_bank;
    logic [31:0]            q;
    logic                   e;
    time                    t0;
    int                     errors = 0;
    int                     check_count = 0;
    int                     cyc = 0;

    always #5 clk = ~clk;
    sdram_read_burst_control #(.DQ_W(8)) u_sdram_read_burst_control (
        .clk             (clk),
        .rst             (rst),
        .apb_req         (apb_req),
        .apb_rsp         (apb_rsp),
        .cmd             (cmd),
        .fetch_addr      (fetch_addr),
        .fetch_data      (fetch_data),
        .dq_out          (dq_out),
        .dq_oe_n         (dq_oe_n),
        .dqs_out         (dqs_out),
        .dqs_oe_n        (dqs_oe_n),
        .wr_data_expect  (wr_data_expect),
        .precharge_start (precharge_start),
        .precharge_bank  (precharge_bank)
    );
    array_model #(.DQ_W(8)) u_array_model (
        .fetch_addr (fetch_addr),
        .fetch_data (fetch_data)
    );

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk) apb_req.penable <= 1'b1;
        @(posedge clk);
        while (apb_rsp.pready !== 1'b1) @(posedge clk);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req <= '0;
    endtask

    task do_rd(input logic ch, ap, input logic [3:0] bk, input int g, rl, n);
        int k;
        logic [7:0] b;
        @(posedge clk) cmd <= '{rd_burst_pkg::CMD_RD, bk, ap, ch, 10'h010};
        t0 = $time;
        @(posedge clk) cmd <= '0;
        if (g > 0) begin
            repeat (g - 2) @(posedge clk);
            @(posedge clk) cmd <= '{rd_burst_pkg::CMD_RD, bk, ap, ch, 10'h010};
            @(posedge clk) cmd <= '0;
        end
        for (k = 0; k < 80 && dq_oe_n !== 1'b0; k++) @(negedge clk);
        chk("read latency", rl, 32'(($time - t0) / 10));
        chk("first beat pair", 32'h0000_10EF, {16'h0000, dq_out});
        // every pair of the burst or of back-to-back bursts up to the first gap, column advancing by two per clock
        for (k = 0; k < 20 && dq_oe_n === 1'b0; k++) begin
            b = 8'h10 + 8'(2 * (k % 4));
            chk("beat pair", {16'h0000, b, ~b}, {16'h0000, dq_out});
            @(negedge clk);
        end
        chk("data clocks", n, k);
        chk("precharge pulse", {31'h0, ap}, {31'h0, precharge_start});
    endtask

    task do_wr(input int wl);
        int k;
        @(posedge clk) cmd <= '{rd_burst_pkg::CMD_WR, 4'h0, 1'b0, 1'b0, 10'h000};
        t0 = $time;
        @(posedge clk) cmd <= '0;
        for (k = 0; k < 80 && wr_data_expect !== 1'b1; k++) @(negedge clk);
        chk("write latency", wl, 32'(($time - t0) / 10));
    endtask

    task t_regs;
        apb(1'b0, `REG_LAT, 32'h0000_0000);
        chk("latency reset", `LAT_RST, q);
        apb(1'b0, `REG_MODE, 32'h0000_0000);
        chk("mode reset", `MODE_RST, q);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, {31'h0, e});
        $display("test registers finished");
    endtask

    task t_modes;
        do_rd(1'b0, 1'b0, 4'h1, 0, 11, 4);
        apb(1'b1, `REG_MODE, 32'h0000_0001);
        do_rd(1'b0, 1'b0, 4'h1, 0, 11, 2);
        do_rd(1'b1, 1'b0, 4'h1, 0, 11, 4);
        apb(1'b1, `REG_MODE, 32'h0000_0002);
        do_rd(1'b1, 1'b0, 4'h1, 0, 11, 2);
        apb(1'b1, `REG_MODE, 32'h0000_0004);
        // four apart is legal even with the long preamble, five is not
        do_rd(1'b1, 1'b0, 4'h1, 4, 11, 8);
        apb(1'b1, `REG_MODE, 32'h0000_0000);
        $display("test burst modes finished");
    endtask

    task t_bank;
        @(posedge clk) cmd <= '{rd_burst_pkg::CMD_ACT, 4'h2, 1'b0, 1'b0, 10'h000};
        @(posedge clk) cmd <= '0;
        apb(1'b0, `REG_BANK, 32'h0000_0000);
        chk("bank open", 32'h0000_0004, q);
        do_rd(1'b0, 1'b0, 4'h2, 0, 11, 4);
        apb(1'b0, `REG_BANK, 32'h0000_0000);
        chk("bank after read", 32'h0000_0004, q);
        do_rd(1'b1, 1'b1, 4'h2, 0, 11, 4);
        chk("precharge bank", 32'h0000_0002, {28'h0, precharge_bank});
        apb(1'b0, `REG_BANK, 32'h0000_0000);
        chk("bank after auto precharge", 32'h0000_0000, q);
        $display("test bank state finished");
    endtask

    task t_err;
        apb(1'b0, `REG_ERR, 32'h0000_0000);
        chk("no spacing error", 32'h0000_0000, q);
        apb(1'b1, `REG_MODE, 32'h0000_0004);
        // deliberate misuse: five apart with long preamble, then an early precharge
        do_rd(1'b1, 1'b0, 4'h1, 5, 11, 4);
        @(posedge clk) cmd <= '{rd_burst_pkg::CMD_RD, 4'h1, 1'b0, 1'b1, 10'h010};
        @(posedge clk) cmd <= '0;
        @(posedge clk) cmd <= '{rd_burst_pkg::CMD_PRE, 4'h1, 1'b0, 1'b0, 10'h000};
        @(posedge clk) cmd <= '0;
        repeat (16) @(posedge clk);
        apb(1'b0, `REG_ERR, 32'h0000_0000);
        chk("spacing errors flagged", 32'h0000_0005, q);
        apb(1'b1, `REG_ERR, 32'h0000_0007);
        apb(1'b0, `REG_ERR, 32'h0000_0000);
        chk("errors cleared", 32'h0000_0000, q);
        apb(1'b1, `REG_MODE, 32'h0000_0000);
        $display("test spacing errors finished");
    endtask

    task t_lat;
        do_wr(9);
        apb(1'b1, `REG_LAT, 32'h000A_090B);
        apb(1'b0, `REG_LAT, 32'h0000_0000);
        chk("latency write", 32'h000A_090B, q);
        do_rd(1'b1, 1'b0, 4'h3, 0, 21, 4);
        do_wr(19);
        // long write preamble runs with cwl one above the base setting
        apb(1'b1, `REG_LAT, 32'h0000_0A0B);
        apb(1'b1, `REG_MODE, 32'h0000_0008);
        do_wr(10);
        apb(1'b1, `REG_MODE, 32'h0000_0000);
        $display("test latencies finished");
    endtask

    task complete_run;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ceiling well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            complete_run;
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_modes;
        t_bank;
        t_err;
        t_lat;
        complete_run;
    end
endmodule
